/* File: bcs_pkg.sv */
// bcs_pkg: register map, reset values and state type of the charge handler
// assumes a 32-bit apb slave with word-aligned registers
package bcs_pkg;
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_state = 8'h04;
  localparam logic [7:0] off_fault_mask = 8'h08;
  localparam logic [7:0] off_recov_thr = 8'h0c;
  localparam logic [7:0] off_overvolt = 8'h10;
  localparam logic [7:0] off_capacity = 8'h14;
  localparam logic [7:0] off_cond_lim = 8'h18;
  localparam logic [7:0] off_recov_lim = 8'h1c;
  localparam logic [7:0] off_bulk_lim = 8'h20;
  localparam logic [7:0] off_fin_lim = 8'h24;
  localparam logic [7:0] off_maint_lim = 8'h28;
  localparam logic [7:0] off_irq_status = 8'h2c;
  localparam logic [7:0] off_irq_mask = 8'h30;
  // ctrl fields
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_start_bit = 1;
  // timeout_fault_mask bits
  localparam int mask_recovery_bit = 0;
  localparam int mask_bulk_bit = 1;
  localparam int mask_finishing_bit = 2;
  localparam int mask_maintenance_bit = 3;
  // irq status bits
  localparam int irq_phase_bit = 0;
  localparam int irq_fault_bit = 1;
  localparam int irq_timeout_bit = 2;
  localparam int irq_count = 3;
  // reset values
  localparam logic [3:0] rst_fault_mask = 4'h0;
  localparam logic [7:0] rst_recov_thr = 8'h28;
  localparam logic [7:0] rst_overvolt = 8'hff;
  localparam logic [15:0] rst_capacity = 16'h0258;
  localparam logic [7:0] rst_cond_lim = 8'h64;
  localparam logic [7:0] rst_recov_lim = 8'h10;
  localparam logic [7:0] rst_bulk_lim = 8'h5a;
  localparam logic [7:0] rst_fin_lim = 8'h5a;
  localparam logic [7:0] rst_maint_lim = 8'h00;
  // percent of capacity ending the bulk and finishing phases
  localparam logic [7:0] bulk_percent = 8'd90;
  localparam logic [7:0] finishing_percent = 8'd100;
  // minute ticks per time-limit unit outside the conditioning phase
  localparam int ticks_per_unit = 2;
  typedef enum logic [2:0] {
    st_idle,
    conditioning_phase,
    recovery_phase,
    bulk_phase,
    finishing_phase,
    maintenance_phase,
    charge_fault_state
  } bcs_state_t;
endpackage

/* File: bcs_phase_timer.sv */
// bcs_phase_timer: per-phase timeout counter
// assumes tick inputs are one-cycle pulses synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module bcs_phase_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic fast_units,
  input wire logic [7:0] limit,
  // ticks
  input wire logic tick_100ms,
  input wire logic tick_minute,
  // result
  output logic expired
);
  logic [7:0] cnt;
  logic [1:0] sub;
  logic done;
  logic unit_tick;

  // conditioning counts 100 ms, others count pairs of minute ticks
  always_comb
  begin
    unit_tick = fast_units ? tick_100ms :
      (tick_minute && sub == 2'(bcs_pkg::ticks_per_unit - 1));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00;
      sub <= 2'h0;
      done <= 1'b0;
    end
    else if (restart)
    begin
      cnt <= 8'h00;
      sub <= 2'h0;
      done <= 1'b0;
    end
    else if (!done)
    begin
      if (tick_minute && !fast_units)
        sub <= (sub == 2'(bcs_pkg::ticks_per_unit - 1)) ? 2'h0 : sub + 2'h1;
      if (unit_tick)
      begin
        cnt <= cnt + 8'h01;
        if (cnt + 8'h01 == limit)
          done <= 1'b1;
      end
    end
  end

  // zero limit never expires; restart kept out to avoid a loop via next state
  assign expired = !done && unit_tick && limit != 8'h00 &&
    cnt + 8'h01 == limit;

  a_zero_limit_off: assert property (@(posedge pclk) disable iff (!presetn)
    limit == 8'h00 |-> !expired)
    else $error("timer expired with zero limit");
endmodule // bcs_phase_timer
`default_nettype wire

/* File: bcs_irq.sv */
// bcs_irq: sticky event bits, mask and level interrupt
// assumes rd_clear is a one-cycle pulse on the read of the status word
`timescale 1ns/1ns
`default_nettype none
module bcs_irq (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events and software access
  input wire logic [2:0] events,
  input wire logic rd_clear,
  input wire logic [2:0] mask,
  // state
  output logic [2:0] status,
  output logic irq
);
  genvar i;
  generate
    for (i = 0; i < bcs_pkg::irq_count; i++)
    begin : g_bit
      // set wins over read clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          status[i] <= 1'b0;
        else if (events[i])
          status[i] <= 1'b1;
        else if (rd_clear)
          status[i] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(status & mask);

  a_event_sticks: assert property (@(posedge pclk) disable iff (!presetn)
    events[0] |=> status[0])
    else $error("event bit not set");
endmodule // bcs_irq
`default_nettype wire

/* File: bcs_charger.sv */
// bcs_charger: battery charge phase handler with apb registers
// assumes ticks and measurements are synchronous to pclk
//
// What this block does
// - phase ends on timeout or completion event
// - fault on error timeout or overvoltage
// - mask picks advance or fault per timeout, except conditioning which always advances
// - mask bits 0..3: recovery, bulk, finishing, maintenance
// - mask resets to zero
// - recovery ends at voltage threshold, default 0x28
// - bulk ends at 90 percent capacity
// - finishing ends at 100 percent capacity
// - zero maintenance limit disables its timeout
// - no negative slope termination
`timescale 1ns/1ns
`default_nettype none
module bcs_charger (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurements and ticks
  input wire logic [7:0] cell_voltage,
  input wire logic [15:0] charge_delivered,
  input wire logic tick_100ms,
  input wire logic tick_minute,
  // charger side
  output logic [2:0] phase,
  output logic charger_on,
  output logic fault,
  output logic irq
);
  bcs_pkg::bcs_state_t state;
  bcs_pkg::bcs_state_t next_state;
  logic enable;
  logic start;
  logic [3:0] timeout_fault_mask;
  logic [7:0] recovery_voltage_threshold;
  logic [7:0] overvolt_limit;
  logic [15:0] cell_capacity_estimate;
  logic [7:0] conditioning_time_limit;
  logic [7:0] recovery_time_limit;
  logic [7:0] bulk_time_limit;
  logic [7:0] finishing_time_limit;
  logic [7:0] maintenance_time_limit;
  logic [2:0] irq_mask;
  logic [2:0] irq_status;
  logic [7:0] limit;
  logic timed_out;
  logic to_fault;
  logic overvolt;
  logic recovery_complete_event;
  logic bulk_complete_event;
  logic finishing_complete_event;
  logic [25:0] delivered_pct;
  logic [25:0] cap_bulk;
  logic [25:0] cap_fin;
  logic wr;
  logic rd_setup;
  logic rd_access;
  logic mapped;
  logic [31:0] rd_mux;
  logic [2:0] events;

  // apb decode: answer in the access cycle, no wait states
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      bcs_pkg::off_ctrl: rd_mux = {31'h0, enable};
      bcs_pkg::off_state: rd_mux = {29'h0, state};
      bcs_pkg::off_fault_mask: rd_mux = {28'h0, timeout_fault_mask};
      bcs_pkg::off_recov_thr: rd_mux = {24'h0, recovery_voltage_threshold};
      bcs_pkg::off_overvolt: rd_mux = {24'h0, overvolt_limit};
      bcs_pkg::off_capacity: rd_mux = {16'h0, cell_capacity_estimate};
      bcs_pkg::off_cond_lim: rd_mux = {24'h0, conditioning_time_limit};
      bcs_pkg::off_recov_lim: rd_mux = {24'h0, recovery_time_limit};
      bcs_pkg::off_bulk_lim: rd_mux = {24'h0, bulk_time_limit};
      bcs_pkg::off_fin_lim: rd_mux = {24'h0, finishing_time_limit};
      bcs_pkg::off_maint_lim: rd_mux = {24'h0, maintenance_time_limit};
      bcs_pkg::off_irq_status: rd_mux = {29'h0, irq_status};
      bcs_pkg::off_irq_mask: rd_mux = {29'h0, irq_mask};
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_mux;
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable <= 1'b0;
      timeout_fault_mask <= bcs_pkg::rst_fault_mask;
      recovery_voltage_threshold <= bcs_pkg::rst_recov_thr;
      overvolt_limit <= bcs_pkg::rst_overvolt;
      cell_capacity_estimate <= bcs_pkg::rst_capacity;
      conditioning_time_limit <= bcs_pkg::rst_cond_lim;
      recovery_time_limit <= bcs_pkg::rst_recov_lim;
      bulk_time_limit <= bcs_pkg::rst_bulk_lim;
      finishing_time_limit <= bcs_pkg::rst_fin_lim;
      maintenance_time_limit <= bcs_pkg::rst_maint_lim;
      irq_mask <= 3'h0;
    end
    else if (wr)
    begin
      unique case (paddr)
        bcs_pkg::off_ctrl: enable <= pwdata[bcs_pkg::ctrl_enable_bit];
        bcs_pkg::off_fault_mask: timeout_fault_mask <= pwdata[3:0];
        bcs_pkg::off_recov_thr: recovery_voltage_threshold <= pwdata[7:0];
        bcs_pkg::off_overvolt: overvolt_limit <= pwdata[7:0];
        bcs_pkg::off_capacity: cell_capacity_estimate <= pwdata[15:0];
        bcs_pkg::off_cond_lim: conditioning_time_limit <= pwdata[7:0];
        bcs_pkg::off_recov_lim: recovery_time_limit <= pwdata[7:0];
        bcs_pkg::off_bulk_lim: bulk_time_limit <= pwdata[7:0];
        bcs_pkg::off_fin_lim: finishing_time_limit <= pwdata[7:0];
        bcs_pkg::off_maint_lim: maintenance_time_limit <= pwdata[7:0];
        bcs_pkg::off_irq_mask: irq_mask <= pwdata[2:0];
        default:
        begin
        end
      endcase
    end
  end

  assign start = wr && paddr == bcs_pkg::off_ctrl &&
    pwdata[bcs_pkg::ctrl_start_bit] && pwdata[bcs_pkg::ctrl_enable_bit];

  // event recognizer: level and percent compares
  // only level compares exist, so no slope detection can end a phase
  assign delivered_pct = 26'(charge_delivered) * 26'd100;
  assign cap_bulk = 26'(cell_capacity_estimate) * 26'(bcs_pkg::bulk_percent);
  assign cap_fin = 26'(cell_capacity_estimate) * 26'(bcs_pkg::finishing_percent);
  assign recovery_complete_event = cell_voltage >= recovery_voltage_threshold;
  assign bulk_complete_event = delivered_pct >= cap_bulk;
  assign finishing_complete_event = delivered_pct >= cap_fin;
  assign overvolt = cell_voltage >= overvolt_limit;

  // limit for the running phase
  always_comb
  begin
    unique case (state)
      bcs_pkg::conditioning_phase: limit = conditioning_time_limit;
      bcs_pkg::recovery_phase: limit = recovery_time_limit;
      bcs_pkg::bulk_phase: limit = bulk_time_limit;
      bcs_pkg::finishing_phase: limit = finishing_time_limit;
      bcs_pkg::maintenance_phase: limit = maintenance_time_limit;
      default: limit = 8'h00;
    endcase
  end

  bcs_phase_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .restart(next_state != state),
    .fast_units(state == bcs_pkg::conditioning_phase),
    .limit(limit),
    .tick_100ms(tick_100ms),
    .tick_minute(tick_minute),
    .expired(timed_out)
  );

  // mask bit of the running phase
  always_comb
  begin
    unique case (state)
      bcs_pkg::recovery_phase:
        to_fault = timeout_fault_mask[bcs_pkg::mask_recovery_bit];
      bcs_pkg::bulk_phase:
        to_fault = timeout_fault_mask[bcs_pkg::mask_bulk_bit];
      bcs_pkg::finishing_phase:
        to_fault = timeout_fault_mask[bcs_pkg::mask_finishing_bit];
      bcs_pkg::maintenance_phase:
        to_fault = timeout_fault_mask[bcs_pkg::mask_maintenance_bit];
      default: to_fault = 1'b0;
    endcase
  end

  // phase sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      bcs_pkg::st_idle, bcs_pkg::charge_fault_state:
        if (start)
          next_state = bcs_pkg::conditioning_phase;
      bcs_pkg::conditioning_phase:
        if (timed_out)
          next_state = bcs_pkg::recovery_phase;
      bcs_pkg::recovery_phase:
        if (recovery_complete_event || timed_out)
          next_state = bcs_pkg::bulk_phase;
      bcs_pkg::bulk_phase:
        if (bulk_complete_event || timed_out)
          next_state = bcs_pkg::finishing_phase;
      bcs_pkg::finishing_phase:
        if (finishing_complete_event || timed_out)
          next_state = bcs_pkg::maintenance_phase;
      bcs_pkg::maintenance_phase:
        if (timed_out)
          next_state = bcs_pkg::st_idle;
      default: next_state = bcs_pkg::st_idle;
    endcase
    // error timeout or overvoltage override the normal advance
    if (state != bcs_pkg::st_idle && state != bcs_pkg::charge_fault_state &&
        ((timed_out && to_fault) || overvolt))
      next_state = bcs_pkg::charge_fault_state;
    if (!enable && !start)
      next_state = bcs_pkg::st_idle;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= bcs_pkg::st_idle;
    else
      state <= next_state;
  end

  // outputs from state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 3'h0;
      charger_on <= 1'b0;
      fault <= 1'b0;
    end
    else
    begin
      phase <= next_state;
      charger_on <= next_state != bcs_pkg::st_idle &&
        next_state != bcs_pkg::charge_fault_state;
      fault <= next_state == bcs_pkg::charge_fault_state;
    end
  end

  // interrupts
  always_comb
  begin
    events = 3'h0;
    events[bcs_pkg::irq_phase_bit] = next_state != state;
    events[bcs_pkg::irq_fault_bit] = next_state == bcs_pkg::charge_fault_state &&
      state != bcs_pkg::charge_fault_state;
    events[bcs_pkg::irq_timeout_bit] = timed_out;
  end

  bcs_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(events),
    .rd_clear(rd_access && paddr == bcs_pkg::off_irq_status),
    .mask(irq_mask),
    .status(irq_status),
    .irq(irq)
  );

  a_recov_advance: assert property (@(posedge pclk) disable iff (!presetn)
    state == bcs_pkg::recovery_phase && enable && !overvolt &&
    recovery_complete_event |=> state == bcs_pkg::bulk_phase)
    else $error("recovery did not end on voltage");
  a_bulk_advance: assert property (@(posedge pclk) disable iff (!presetn)
    state == bcs_pkg::bulk_phase && enable && !overvolt &&
    bulk_complete_event |=> state == bcs_pkg::finishing_phase)
    else $error("bulk did not end at 90 percent");
  a_fin_advance: assert property (@(posedge pclk) disable iff (!presetn)
    state == bcs_pkg::finishing_phase && enable && !overvolt &&
    finishing_complete_event |=> state == bcs_pkg::maintenance_phase)
    else $error("finishing did not end at 100 percent");
  a_timeout_fault: assert property (@(posedge pclk) disable iff (!presetn)
    timed_out && to_fault && enable |=> state == bcs_pkg::charge_fault_state)
    else $error("masked timeout did not fault");
  a_timeout_next: assert property (@(posedge pclk) disable iff (!presetn)
    timed_out && !to_fault && !overvolt && enable &&
    state == bcs_pkg::bulk_phase |=> state == bcs_pkg::finishing_phase)
    else $error("clear mask bit did not advance");
  a_overvolt_fault: assert property (@(posedge pclk) disable iff (!presetn)
    overvolt && enable && charger_on && phase == state |=>
    state == bcs_pkg::charge_fault_state ##1 fault)
    else $error("overvoltage did not fault");
  a_order_kept: assert property (@(posedge pclk) disable iff (!presetn)
    state == bcs_pkg::conditioning_phase && $changed(state) == 1'b0 &&
    next_state != state && enable && !overvolt |->
    next_state == bcs_pkg::recovery_phase)
    else $error("conditioning left out of order");
  a_event_change: assert property (@(posedge pclk) disable iff (!presetn)
    state inside {bcs_pkg::recovery_phase, bcs_pkg::bulk_phase,
    bcs_pkg::finishing_phase} && $past(state) == state && $changed(state) == 1'b0 ##1
    state != $past(state) && $past(state) != bcs_pkg::st_idle |->
    $past(timed_out || recovery_complete_event || bulk_complete_event ||
    finishing_complete_event || overvolt || !enable))
    else $error("phase changed without cause");
  a_mask_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> timeout_fault_mask == 4'h0)
    else $error("mask not zero after reset");
endmodule // bcs_charger
`default_nettype wire

/* File: bcs_cell_model.sv */
// bcs_cell_model: cell voltage and charge estimate path facing the handler
// assumes tick_minute is a one-cycle pulse and phase code 0 means idle
`timescale 1ns/1ns
`default_nettype none
module bcs_cell_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // handler side
  input wire logic charger_on,
  input wire logic [2:0] phase,
  input wire logic tick_minute,
  // bench settings
  input wire logic [7:0] volt_set,
  input wire logic [15:0] charge_step,
  // measurements
  output logic [7:0] cell_voltage,
  output logic [15:0] charge_delivered
);
  assign cell_voltage = volt_set;
  // charge grows per minute while the charger is on, cleared in idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      charge_delivered <= 16'h0000;
    else if (phase == 3'h0)
      charge_delivered <= 16'h0000;
    else if (charger_on && tick_minute)
      charge_delivered <= charge_delivered + charge_step;
  end
endmodule // bcs_cell_model
`default_nettype wire

/* File: bcs_charger_tb.sv */
// bcs_charger_tb: apb-driven sequences over the charge phase handler
// assumes bcs_pkg, bcs_charger and bcs_cell_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module bcs_charger_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e, tick_100ms, tick_minute, charger_on, fault, irq;
  logic [7:0] cell_voltage, volt;
  logic [15:0] charge_delivered, step;
  logic [2:0] phase;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] ra [10] = '{bcs_pkg::off_state, bcs_pkg::off_fault_mask, bcs_pkg::off_recov_thr,
    bcs_pkg::off_overvolt, bcs_pkg::off_capacity, bcs_pkg::off_cond_lim,
    bcs_pkg::off_recov_lim, bcs_pkg::off_bulk_lim, bcs_pkg::off_fin_lim, bcs_pkg::off_maint_lim};
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h28, 32'hff, 32'h258, 32'h64, 32'h10, 32'h5a,
    32'h5a, 32'h0};

  bcs_charger dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_voltage(cell_voltage), .charge_delivered(charge_delivered),
    .tick_100ms(tick_100ms), .tick_minute(tick_minute), .phase(phase),
    .charger_on(charger_on), .fault(fault), .irq(irq));
  bcs_cell_model cell_u (.pclk(pclk), .presetn(presetn), .charger_on(charger_on),
    .phase(phase), .tick_minute(tick_minute), .volt_set(volt), .charge_step(step),
    .cell_voltage(cell_voltage), .charge_delivered(charge_delivered));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: value %h expected %h", $time, got, exp);
    end
  endtask

  // phase code together with charger_on and fault
  task automatic chk_st(input logic [2:0] p);
    checked++;
    if (phase !== p || charger_on !== (p >= 3'h1 && p <= 3'h5) || fault !== (p == 3'h6))
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: phase %h expected %h", $time, phase, p);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: no pready", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic tick_m(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      tick_minute <= 1'b1;
      @(posedge pclk);
      tick_minute <= 1'b0;
    end
    settle();
  endtask

  task automatic tick_c();
    @(posedge pclk);
    tick_100ms <= 1'b1;
    @(posedge pclk);
    tick_100ms <= 1'b0;
    settle();
  endtask

  task automatic setm(input logic [7:0] v, input logic [15:0] s);
    @(posedge pclk);
    volt <= v;
    step <= s;
    settle();
  endtask

  initial
  begin
    #500_000;
    error_cnt++;
    $display("[FAIL] %0t ns: timeout", $time);
    close_out();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick_100ms = 1'b0;
    tick_minute = 1'b0;
    volt = 8'h00;
    step = 16'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped address
    for (int i = 0; i < 10; i++)
      rd(ra[i], rv[i]);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    // every timeout with each mask bit set in turn, then none
    foreach (ra[i])
      if (i >= 5)
        wr(ra[i], 32'h1);
    wr(bcs_pkg::off_capacity, 32'h64);
    for (int i = 0; i < 5; i++)
    begin
      wr(bcs_pkg::off_fault_mask, i < 4 ? 32'h1 << i : 32'h0);
      wr(bcs_pkg::off_ctrl, 32'h3);
      settle();
      chk_st(3'h1);
      tick_c();
      chk_st(3'h2);
      for (int p = 0; p < 4 && p <= i; p++)
      begin
        tick_m(1);
        chk_st(3'(p + 2));
        tick_m(1);
        if (p == i)
          chk_st(3'h6);
        else
          chk_st(p == 3 ? 3'h0 : 3'(p + 3));
      end
    end
    // event-driven phase ends
    for (int i = 7; i < 10; i++)
      wr(ra[i], 32'h0);
    setm(8'h27, 16'h000a);
    wr(bcs_pkg::off_ctrl, 32'h3);
    settle();
    tick_c();
    chk_st(3'h2);
    setm(8'h28, 16'h000a);
    chk_st(3'h3);
    setm(8'h10, 16'h000a);
    chk_st(3'h3);
    tick_m(8);
    chk_st(3'h3);
    tick_m(1);
    chk_st(3'h4);
    tick_m(1);
    chk_st(3'h5);
    tick_m(6);
    chk_st(3'h5);
    // masked status, read clear, overvoltage fault interrupt
    chk({31'h0, irq}, 32'h0);
    rd(bcs_pkg::off_irq_status, 32'h7);
    rd(bcs_pkg::off_irq_status, 32'h0);
    wr(bcs_pkg::off_irq_mask, 32'h2);
    wr(bcs_pkg::off_overvolt, 32'h80);
    setm(8'h80, 16'h0000);
    chk_st(3'h6);
    chk({31'h0, irq}, 32'h1);
    rd(bcs_pkg::off_irq_status, 32'h3);
    settle();
    chk({31'h0, irq}, 32'h0);
    // disable drops to idle
    setm(8'h00, 16'h0000);
    wr(bcs_pkg::off_ctrl, 32'h3);
    settle();
    chk_st(3'h1);
    wr(bcs_pkg::off_ctrl, 32'h0);
    settle();
    chk_st(3'h0);
    close_out();
  end
endmodule // bcs_charger_tb
`default_nettype wire
